// ### hdl/twsc_pkg.sv
// Constants and types for the three-wire synthesizer control port.
// Assumes a single 50 MHz system clock and asynchronous reset.
`default_nettype none
package twsc_pkg;

    localparam int          CLK_HZ        = 50000000;
    localparam int          WORD_BITS     = 27;
    localparam int          CNT_W         = 5;

    // Bit counts at which the fields latch and the counter saturates
    localparam logic [4:0]  BAND_LATCH    = 5'h04;
    localparam logic [4:0]  DIV_LATCH     = 5'h13;
    localparam logic [4:0]  CTRL_LATCH    = 5'h1A;
    localparam logic [4:0]  CNT_FULL      = 5'h1B;

    // Field widths
    localparam int          BAND_W        = 4;
    localparam int          DIV_W         = 15;
    localparam int          CTRL_W        = 7;
    localparam int          REF_W         = 7;

    // Test select codes
    localparam logic [2:0]  TEST_CMP      = 3'h0;
    localparam logic [2:0]  TEST_NORMAL   = 3'h1;
    localparam logic [2:0]  TEST_REF_CNT  = 3'h4;
    localparam logic [2:0]  TEST_REF_HALF = 3'h5;

    // Reference divide ratios
    localparam logic [6:0]  REF_DIV_00    = 7'h0C;
    localparam logic [6:0]  REF_DIV_01    = 7'h10;
    localparam logic [6:0]  REF_DIV_10    = 7'h40;
    localparam logic [6:0]  REF_DIV_11    = 7'h50;

    // Values after reset
    localparam logic [3:0]  BAND_RST      = 4'h0;
    localparam logic [14:0] DIV_RST       = 15'h0400;
    localparam logic [26:0] WORD_RST      = 27'h0000000;

    typedef struct packed {
        logic       pump_current_sel;
        logic [2:0] test_select;
        logic [1:0] ref_divide_sel;
        logic       tuning_amp_off;
    } twsc_ctrl_t;

    localparam twsc_ctrl_t  CTRL_RST      = '{1'b0, TEST_NORMAL, 2'h0, 1'b0};

endpackage : twsc_pkg
`default_nettype wire

// ### hdl/twsc_sync.sv
// Two-stage synchroniser for one asynchronous pin.
// Assumes the pin is stable for several system clocks.
`timescale 1ns/1ps
`default_nettype none
module twsc_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);
    logic meta_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : twsc_sync
`default_nettype wire

// ### hdl/twsc_div.sv
// Programmable divider of an input tick stream.
// Assumes tick is a one-cycle enable in the clk domain; ratio >= 2.
`timescale 1ns/1ps
`default_nettype none
module twsc_div #(
    parameter int WIDTH = 15
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             tick,
    input  wire logic [WIDTH-1:0] ratio,
    output logic                  pulse
);
    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] cnt_nxt;
    logic             wrap;

    assign wrap    = tick && (cnt_r >= ratio - WIDTH'(1));
    assign cnt_nxt = wrap ? '0 : cnt_r + WIDTH'(1);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
            pulse <= 1'b0;
        end else begin
            pulse <= wrap;
            if (tick) begin
                cnt_r <= cnt_nxt;
            end
        end
    end
endmodule : twsc_div
`default_nettype wire

// ### hdl/twsc_top.sv
// Three-wire serial control port with divider, lock and test logic.
// Assumes bus pins are asynchronous and far slower than CLOCK;
// XTAL_TICK and RF_TICK are enables already in the CLOCK domain.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Select pin high picks three-wire bus
// - Whole setup is one 27-bit word
// - Shift data on clock fall during enable
// - 27th fall validates the last 27 bits
// - Band bits latch at 5th bit rise
// - Divide ratio latches at 20th bit rise
// - Control field latches at 27th fall
// - Order: ignored, band 4..1, DIVIDE_RATIO_BITS, control
// - Pump select picks low or high current
// - Test codes route reference and counter outputs
// - Code 000 runs phase comparator test
// - Reference divides crystal by 12/16/64/80
// - Amp off disables amp, output low
// - Output frequency is reference times N
// - Level pin becomes lock output here
// - Lock output low locked, high unlocked
module twsc_top
    import twsc_pkg::*;
(
    input  wire logic              CLOCK,
    input  wire logic              SYS_RST,
    input  wire logic              INTERFACE_SELECT_PIN,
    input  wire logic              THREE_WIRE_CLOCK_IN,
    input  wire logic              SERIAL_DATA_IN,
    input  wire logic              FRAME_ENABLE_IN,
    input  wire logic              XTAL_TICK,
    input  wire logic              RF_TICK,
    output logic                   THREE_WIRE_MODE,
    output logic [3:0]             BAND_OUT,
    output logic [14:0]            DIVIDE_RATIO,
    output twsc_pkg::twsc_ctrl_t   CTRL,
    output logic [26:0]            PROGRAM_WORD,
    output logic                   PUMP_HIGH_CURRENT,
    output logic                   TUNE_AMP_EN,
    output logic                   TUNE_FORCE_LOW,
    output logic                   LOCK_OUT,
    output logic                   LOCK_OE,
    output logic                   COMPARATOR_CHECK_OUT
);
    import twsc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [3:0] pin_raw;
    logic [3:0] pin_s;

    assign pin_raw = {INTERFACE_SELECT_PIN, FRAME_ENABLE_IN,
                      THREE_WIRE_CLOCK_IN, SERIAL_DATA_IN};

    for (genvar i = 0; i < 4; i++) begin : g_sync
        twsc_sync u_sync (
            .clk (CLOCK),
            .rst (SYS_RST),
            .d   (pin_raw[i]),
            .q   (pin_s[i])
        );
    end

    logic sel_s;
    logic en_s;
    logic cl_s;
    logic da_s;
    logic cl_d_r;

    assign sel_s = pin_s[3];
    assign en_s  = pin_s[2];
    assign cl_s  = pin_s[1];
    assign da_s  = pin_s[0];

    ////////////////////////////////////////////////////////////////////////
    // Edge decode

    logic mode3;
    logic active;
    logic fall_evt;
    logic rise_evt;

    assign mode3    = sel_s;
    assign active   = mode3 && en_s;
    assign fall_evt = active && cl_d_r && !cl_s;
    assign rise_evt = active && !cl_d_r && cl_s;

    ////////////////////////////////////////////////////////////////////////
    // Shift register and bit counter

    logic [26:0]      sr_r;
    logic [26:0]      sr_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             cnt_sat;

    assign sr_nxt  = {sr_r[25:0], da_s};
    assign cnt_sat = (cnt_r == CNT_FULL);
    assign cnt_nxt = cnt_sat ? cnt_r : cnt_r + CNT_W'(1);

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cl_d_r <= 1'b0;
            sr_r   <= WORD_RST;
            cnt_r  <= '0;
        end else begin
            cl_d_r <= cl_s;
            if (!active) begin
                cnt_r <= '0;
            end else if (fall_evt) begin
                sr_r  <= sr_nxt;
                cnt_r <= cnt_nxt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Field latches

    logic band_hit;
    logic div_hit;
    logic ctrl_hit;

    logic [3:0]  band_r;
    logic [14:0] div_r;
    twsc_ctrl_t  ctrl_r;
    twsc_ctrl_t  ctrl_nxt;
    logic [26:0] word_r;

    assign band_hit = rise_evt && (cnt_r == BAND_LATCH);
    assign div_hit  = rise_evt && (cnt_r == DIV_LATCH);
    assign ctrl_hit = fall_evt && (cnt_r == CTRL_LATCH);
    assign ctrl_nxt = twsc_ctrl_t'(sr_nxt[6:0]);

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            band_r <= BAND_RST;
            div_r  <= DIV_RST;
            ctrl_r <= CTRL_RST;
            word_r <= WORD_RST;
        end else begin
            if (band_hit) begin
                band_r <= {sr_r[2:0], da_s};
            end
            if (div_hit) begin
                div_r <= {sr_r[13:0], da_s};
            end
            if (ctrl_hit) begin
                ctrl_r <= ctrl_nxt;
                word_r <= sr_nxt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reference divider and programmable counter

    logic [REF_W-1:0] ref_ratio;
    logic             ref_pulse;
    logic             cnt_pulse;

    assign ref_ratio = (ctrl_r.ref_divide_sel == 2'h0) ? REF_DIV_00 :
                       (ctrl_r.ref_divide_sel == 2'h1) ? REF_DIV_01 :
                       (ctrl_r.ref_divide_sel == 2'h2) ? REF_DIV_10 :
                                                         REF_DIV_11;

    twsc_div #(.WIDTH(REF_W)) u_ref_div (
        .clk   (CLOCK),
        .rst   (SYS_RST),
        .tick  (XTAL_TICK),
        .ratio (ref_ratio),
        .pulse (ref_pulse)
    );

    twsc_div #(.WIDTH(DIV_W)) u_prog_div (
        .clk   (CLOCK),
        .rst   (SYS_RST),
        .tick  (RF_TICK),
        .ratio (div_r),
        .pulse (cnt_pulse)
    );

    ////////////////////////////////////////////////////////////////////////
    // Lock detector: one counter pulse per reference period

    logic [1:0] seen_r;
    logic [1:0] seen_nxt;
    logic       locked_r;

    assign seen_nxt = (seen_r == 2'h3) ? seen_r : seen_r + 2'h1;

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            seen_r   <= 2'h0;
            locked_r <= 1'b0;
        end else if (ref_pulse) begin
            locked_r <= ((seen_r + {1'b0, cnt_pulse}) == 2'h1);
            seen_r   <= 2'h0;
        end else if (cnt_pulse) begin
            seen_r   <= seen_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Test signals and output mux

    logic ref_sq_r;
    logic cnt_sq_r;
    logic half_sq_r;

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ref_sq_r  <= 1'b0;
            cnt_sq_r  <= 1'b0;
            half_sq_r <= 1'b0;
        end else begin
            if (ref_pulse) begin
                ref_sq_r <= !ref_sq_r;
            end
            if (cnt_pulse) begin
                cnt_sq_r <= !cnt_sq_r;
                if (cnt_sq_r) begin
                    half_sq_r <= !half_sq_r;
                end
            end
        end
    end

    logic       test_ref;
    logic       test_half;
    logic       test_cmp;
    logic [3:0] band_nxt;
    logic       lock_nxt;
    logic       cmp_nxt;

    assign test_ref  = (ctrl_r.test_select == TEST_REF_CNT);
    assign test_half = (ctrl_r.test_select == TEST_REF_HALF);
    assign test_cmp  = (ctrl_r.test_select == TEST_CMP);

    assign band_nxt = test_ref  ? {ref_sq_r, band_r[2], cnt_sq_r, band_r[0]} :
                      test_half ? {ref_sq_r, band_r[2], half_sq_r, band_r[0]} :
                                  band_r;
    assign lock_nxt = !locked_r;
    assign cmp_nxt  = test_cmp && mode3 && (da_s ^ cl_s);

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            BAND_OUT             <= BAND_RST;
            LOCK_OUT             <= 1'b1;
            COMPARATOR_CHECK_OUT <= 1'b0;
        end else begin
            BAND_OUT             <= band_nxt;
            LOCK_OUT             <= lock_nxt;
            COMPARATOR_CHECK_OUT <= cmp_nxt;
        end
    end

    assign THREE_WIRE_MODE   = mode3;
    assign LOCK_OE           = mode3;
    assign DIVIDE_RATIO      = div_r;
    assign CTRL              = ctrl_r;
    assign PROGRAM_WORD      = word_r;
    assign PUMP_HIGH_CURRENT = ctrl_r.pump_current_sel;
    assign TUNE_AMP_EN       = !ctrl_r.tuning_amp_off;
    assign TUNE_FORCE_LOW    = ctrl_r.tuning_amp_off;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_shift;
        @(posedge CLOCK) disable iff (SYS_RST)
        fall_evt |=> sr_r == {$past(sr_r[25:0]), $past(da_s)};
    endproperty
    a_shift: assert property (p_shift) else $error("shift wrong");

    property p_band;
        @(posedge CLOCK) disable iff (SYS_RST)
        band_hit |=> band_r == $past({sr_r[2:0], da_s});
    endproperty
    a_band: assert property (p_band) else $error("band latch wrong");

    property p_div;
        @(posedge CLOCK) disable iff (SYS_RST)
        div_hit |=> div_r == $past({sr_r[13:0], da_s});
    endproperty
    a_div: assert property (p_div) else $error("divider latch wrong");

    property p_ctrl;
        @(posedge CLOCK) disable iff (SYS_RST)
        (fall_evt && cnt_r == CTRL_LATCH) |=> ctrl_r == $past(sr_nxt[6:0]) && word_r == sr_r;
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("control latch wrong");

    property p_hold;
        @(posedge CLOCK) disable iff (SYS_RST)
        !active |=> $stable(band_r) && $stable(div_r) && $stable(ctrl_r);
    endproperty
    a_hold: assert property (p_hold) else $error("fields moved idle");

    property p_lockpin;
        @(posedge CLOCK) disable iff (SYS_RST)
        LOCK_OE == sel_s;
    endproperty
    a_lockpin: assert property (p_lockpin) else $error("lock pin enable wrong");

    property p_lock;
        @(posedge CLOCK) disable iff (SYS_RST)
        ##1 LOCK_OUT == !$past(locked_r);
    endproperty
    a_lock: assert property (p_lock) else $error("lock level wrong");

    property p_amp;
        @(posedge CLOCK) disable iff (SYS_RST)
        ctrl_r.tuning_amp_off |-> !TUNE_AMP_EN && TUNE_FORCE_LOW;
    endproperty
    a_amp: assert property (p_amp) else $error("amp off wrong");

    property p_ref;
        @(posedge CLOCK) disable iff (SYS_RST)
        ctrl_r.ref_divide_sel == 2'h3 |-> ref_ratio == 7'h50;
    endproperty
    a_ref: assert property (p_ref) else $error("ref ratio wrong");

endmodule : twsc_top
`default_nettype wire

// ### verif/twsc_host_model.sv
// Host controller model driving the three-wire bus.
// Assumes clk is the system clock; levels held 8 cycles each, 4 after enable falls.
`timescale 1ns/1ps
`default_nettype none
module twsc_host_model (
    input  wire logic clk,
    output logic      sclk,
    output logic      sdata,
    output logic      sen
);
    initial begin
        sclk  = 1'b0;
        sdata = 1'b0;
        sen   = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : hold
    // Sends n bits of w from w[29] down, clock idle low
    task automatic send(input logic [29:0] w, input int n);
        sen = 1'b1;
        hold(8);
        for (int i = 0; i < n; i++) begin
            sdata = w[29-i];
            hold(8);
            sclk = 1'b1;
            hold(8);
            sclk = 1'b0;
            hold(8);
        end
        sen = 1'b0;
        hold(4);
        sdata = ~sdata;
        hold(8);
    endtask : send
    task automatic pins(input logic c, input logic d);
        sclk  = c;
        sdata = d;
        hold(8);
    endtask : pins
endmodule : twsc_host_model
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the three-wire synthesizer control port.
// Assumes twsc_top and the host model; ticks toggle every cycle.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import twsc_pkg::*;
    logic clock, sys_rst, sel, xt, rf;
    logic sclk, sdata, sen;
    logic tw_mode, p_hi, amp_en, f_low, lk, lk_oe, cmp;
    logic [3:0] band;
    logic [14:0] div;
    twsc_ctrl_t ctrl;
    logic [26:0] pw, last_w;
    int err_count, checks, cyc;
    twsc_host_model host (.clk(clock), .sclk(sclk), .sdata(sdata), .sen(sen));
    twsc_top dut (.CLOCK(clock), .SYS_RST(sys_rst), .INTERFACE_SELECT_PIN(sel),
        .THREE_WIRE_CLOCK_IN(sclk), .SERIAL_DATA_IN(sdata), .FRAME_ENABLE_IN(sen),
        .XTAL_TICK(xt), .RF_TICK(rf), .THREE_WIRE_MODE(tw_mode), .BAND_OUT(band),
        .DIVIDE_RATIO(div), .CTRL(ctrl), .PROGRAM_WORD(pw), .PUMP_HIGH_CURRENT(p_hi),
        .TUNE_AMP_EN(amp_en), .TUNE_FORCE_LOW(f_low), .LOCK_OUT(lk), .LOCK_OE(lk_oe),
        .COMPARATOR_CHECK_OUT(cmp));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        #1;
        xt = ~xt;
        rf = ~rf;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (err_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t got %0h expected %0h", $time, g, e);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : wt
    function automatic logic [26:0] mk(logic [3:0] b, logic [14:0] n, logic [6:0] c);
        return {1'b0, b, n, c};
    endfunction : mk
    task automatic frame(input logic [26:0] w, input int n, input logic [2:0] t);
        host.send({w, t}, n);
        wt(10);
    endtask : frame
    // Half period of a band output toggle, in cycles
    task automatic per(input int b, output int p);
        logic s;
        int k;
        s = band[b];
        k = 0;
        while (band[b] === s && k < 400) begin
            wt(1);
            k++;
        end
        s = band[b];
        p = 0;
        while (band[b] === s && p < 400) begin
            wt(1);
            p++;
        end
    endtask : per
    ////////////////////////////////////////////////////////////////////
    task automatic s_full(input logic [3:0] b, input logic [14:0] n, input logic [6:0] c);
        last_w = mk(b, n, c);
        frame(last_w, 27, 3'h0);
        chk(pw, last_w);
        chk(band, b);
        chk(div, n);
        chk(ctrl, c);
        chk(p_hi, c[6]);
        chk({amp_en, f_low}, {~c[0], c[0]});
    endtask : s_full
    task automatic s_abort();
        logic [26:0] w;
        w = mk(4'h3, 15'h1111, 7'h4E);
        frame(w, 10, 3'h0);
        chk(band, 4'h3);
        chk(div, last_w[21:7]);
        chk(pw, last_w);
        frame(w, 20, 3'h0);
        chk(div, 15'h1111);
        chk(ctrl, last_w[6:0]);
    endtask : s_abort
    task automatic s_long();
        last_w = mk(4'h9, 15'h0123, 7'h10);
        frame(last_w, 30, 3'h7);
        chk(pw, last_w);
        chk(ctrl, 7'h10);
    endtask : s_long
    task automatic s_two_wire();
        sel = 1'b0;
        wt(6);
        chk({tw_mode, lk_oe}, 2'b00);
        frame(mk(4'hF, 15'h7FFF, 7'h7F), 27, 3'h0);
        chk(pw, last_w);
        chk(div, 15'h0123);
        sel = 1'b1;
        wt(6);
        chk({tw_mode, lk_oe}, 2'b11);
    endtask : s_two_wire
    task automatic s_test();
        logic [6:0] r [4];
        int p;
        r = '{REF_DIV_00, REF_DIV_01, REF_DIV_10, REF_DIV_11};
        for (int i = 0; i < 4; i++) begin
            frame(mk(4'h0, 15'h0005, {1'b0, TEST_REF_CNT, 2'(i), 1'b0}), 27, 3'h0);
            per(3, p);
            chk(p, 2 * r[i]);
            per(1, p);
            chk(p, 10);
        end
        chk(lk, 1'b1);
        frame(mk(4'h0, 15'h0005, {1'b0, TEST_REF_HALF, 3'h0}), 27, 3'h0);
        per(1, p);
        chk(p, 20);
    endtask : s_test
    task automatic s_lock();
        frame(mk(4'h0, 15'h000C, {1'b0, TEST_NORMAL, 3'h0}), 27, 3'h0);
        wt(200);
        chk(lk, 1'b0);
    endtask : s_lock
    task automatic s_cmp();
        frame(mk(4'h0, 15'h000C, {1'b0, TEST_CMP, 3'h0}), 27, 3'h0);
        host.pins(1'b0, 1'b1);
        chk(cmp, 1'b1);
        host.pins(1'b1, 1'b1);
        chk(cmp, 1'b0);
        host.pins(1'b0, 1'b0);
        frame(mk(4'h0, 15'h000C, {1'b0, TEST_NORMAL, 3'h0}), 27, 3'h0);
        host.pins(1'b0, 1'b1);
        chk(cmp, 1'b0);
    endtask : s_cmp
    ////////////////////////////////////////////////////////////////////
    initial begin
        sys_rst   = 1'b1;
        sel       = 1'b1;
        xt        = 1'b0;
        rf        = 1'b0;
        cyc       = 0;
        err_count = 0;
        checks    = 0;
        wt(12);
        chk({band, div, ctrl}, {BAND_RST, DIV_RST, CTRL_RST});
        chk({pw, lk, lk_oe, amp_en}, {WORD_RST, 3'b101});
        sys_rst = 1'b0;
        wt(6);
        s_full(4'hA, 15'h2C35, 7'h1B);
        s_full(4'h5, 15'h53CA, 7'h52);
        s_abort();
        s_long();
        s_two_wire();
        s_test();
        s_lock();
        s_cmp();
        finish_test();
    end
endmodule : testbench
`default_nettype wire
